// file: verilog/edge_event_defs.svh
/*
  Offsets, reset values, response codes and sizes of the edge event controller.
  Assumes byte addresses on a 32-bit AXI4-Lite bus, one register per aligned word.
*/
`ifndef EDGE_EVENT_DEFS_SVH
`define EDGE_EVENT_DEFS_SVH

`define EEC_LINES 29
`define EEC_EXT_LINES 16
`define EEC_INT_LINES 13
`define EEC_GPIOS 84
`define EEC_SEL_W 7
`define EEC_ADDR_W 7

`define EEC_OFF_IMASK 7'h00
`define EEC_OFF_EMASK 7'h04
`define EEC_OFF_RISE 7'h08
`define EEC_OFF_FALL 7'h0C
`define EEC_OFF_PEND 7'h10
`define EEC_OFF_MUX0 7'h20
`define EEC_OFF_MUX1 7'h24
`define EEC_OFF_MUX2 7'h28
`define EEC_OFF_MUX3 7'h2C

`define EEC_RST_MASK 29'h0000000
`define EEC_RST_SEL 7'h00

`define EEC_RESP_OKAY 2'h0
`define EEC_RESP_SLVERR 2'h2

`endif

// file: verilog/edge_event_pkg.sv
/*
  Types shared by the edge event controller files.
  Assumes edge_event_defs.svh gives the line count.
*/
`include "edge_event_defs.svh"

package edge_event_pkg;
  typedef logic [`EEC_LINES-1:0] line_vec_t;
  typedef logic [`EEC_SEL_W-1:0] gpio_sel_t;

  // per-line trigger setup
  typedef struct packed {
    line_vec_t rise;
    line_vec_t fall;
  } trig_cfg_s;
endpackage

// file: verilog/edge_catch.sv
/*
  One edge catcher: flops clocked by the input itself so pulses narrower than
  CLK are still held, then a two-flop synchroniser and a clear handshake.
  Assumes the input stays low or high at least a few ns around each edge.
*/
`timescale 1ns/1ps

module edge_catch (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // line input, any timing
  input wire logic line_in,
  // one-cycle pulses in clk domain
  output logic rise_seen,
  output logic fall_seen
);
  logic rise_catch_q, fall_catch_q;
  logic rise_s1_q, rise_s2_q, fall_s1_q, fall_s2_q;
  logic rise_ack_q, fall_ack_q;
  wire rise_clr = rst | rise_ack_q;
  wire fall_clr = rst | fall_ack_q;

  // asynchronous capture on the line's own edges
  always_ff @(posedge line_in or posedge rise_clr) begin // [R5]
    if (rise_clr) rise_catch_q <= 1'b0;
    else rise_catch_q <= 1'b1;
  end

  always_ff @(negedge line_in or posedge fall_clr) begin // [R5]
    if (fall_clr) fall_catch_q <= 1'b0;
    else fall_catch_q <= 1'b1;
  end

  // synchronise, then clear the catcher until the synchroniser drains
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rise_s1_q <= 1'b0;
      rise_s2_q <= 1'b0;
      fall_s1_q <= 1'b0;
      fall_s2_q <= 1'b0;
      rise_ack_q <= 1'b0;
      fall_ack_q <= 1'b0;
    end else begin
      rise_s1_q <= rise_catch_q;
      rise_s2_q <= rise_s1_q;
      fall_s1_q <= fall_catch_q;
      fall_s2_q <= fall_s1_q;
      rise_ack_q <= rise_s2_q;
      fall_ack_q <= fall_s2_q;
    end
  end

  assign rise_seen = rise_s2_q & ~rise_ack_q;
  assign fall_seen = fall_s2_q & ~fall_ack_q;

  catch_sync_a: assert property (@(posedge clk) disable iff (rst) // [R5]
    $rose(rise_s2_q) |-> rise_seen ##1 !rise_seen)
    else $error("caught rising edge not reported as one pulse");
endmodule

// file: verilog/edge_event_ctrl.sv
/*
  Edge event line controller with an AXI4-Lite register slave.
  Assumes GPIO and internal sources are asynchronous; the AXI master runs on CLK.
*/
// What this block does
// R1: twenty-nine edge lines each raise interrupt, event and wake-up requests.
// R2: each line triggers on rising, falling or both edges.
// R3: each line has its own mask blocking only that line.
// R4: a pending bit per line is set by a selected edge.
// R5: edges narrower than one clock period are still captured.
// R6: sixteen external lines each pick one of 84 GPIO pins.
// R7: software clears pending by writing one; zero writes leave it.
`timescale 1ns/1ps
`include "edge_event_defs.svh"

module edge_event_ctrl (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // axi4-lite write address and data
  input wire logic [`EEC_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // axi4-lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // axi4-lite read
  input wire logic [`EEC_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // line sources
  input wire logic [`EEC_GPIOS-1:0] GPIO,
  input wire logic [`EEC_INT_LINES-1:0] INT_SRC,
  // requests
  output logic IRQ,
  output edge_event_pkg::line_vec_t EVT,
  output logic WAKEUP
);
  edge_event_pkg::line_vec_t imask_q, emask_q, pend_q, pend_d, evt_q;
  edge_event_pkg::trig_cfg_s trig_q;
  edge_event_pkg::gpio_sel_t sel_q [`EEC_EXT_LINES];
  edge_event_pkg::line_vec_t line_in, rise_pulse, fall_pulse, set_vec, clr_vec;

  // external line multiplexers, and catchers for all lines
  genvar g;
  generate
    for (g = 0; g < `EEC_EXT_LINES; g++) begin : g_mux
      assign line_in[g] = (sel_q[g] < 7'(`EEC_GPIOS)) ? GPIO[sel_q[g]] : 1'b0; // [R6]
    end
    for (g = 0; g < `EEC_LINES; g++) begin : g_line
      edge_catch u_catch ( // [R1]
        .clk(CLK),
        .rst(RST),
        .line_in(line_in[g]),
        .rise_seen(rise_pulse[g]),
        .fall_seen(fall_pulse[g])
      );
    end
  endgenerate
  assign line_in[`EEC_LINES-1:`EEC_EXT_LINES] = INT_SRC;

  // edge selection per line
  assign set_vec = (rise_pulse & trig_q.rise) | (fall_pulse & trig_q.fall); // [R2]

  // axi write path: address and data taken in either order
  logic aw_have_q, w_have_q, bvalid_q;
  logic [1:0] bresp_q;
  logic [`EEC_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  wire aw_take = AWVALID & AWREADY;
  wire w_take = WVALID & WREADY;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire [`EEC_ADDR_W-1:0] wa = awaddr_q;
  wire wr_imask = wr_go & (wa == `EEC_OFF_IMASK);
  wire wr_emask = wr_go & (wa == `EEC_OFF_EMASK);
  wire wr_rise = wr_go & (wa == `EEC_OFF_RISE);
  wire wr_fall = wr_go & (wa == `EEC_OFF_FALL);
  wire wr_pend = wr_go & (wa == `EEC_OFF_PEND);
  wire wr_mux = wr_go & (wa >= `EEC_OFF_MUX0) & (wa <= `EEC_OFF_MUX3) & (wa[1:0] == 2'h0);
  wire wr_hit = wr_imask | wr_emask | wr_rise | wr_fall | wr_pend | wr_mux;
  wire [1:0] mux_word = wa[3:2];

  assign AWREADY = ~aw_have_q & ~bvalid_q;
  assign WREADY = ~w_have_q & ~bvalid_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= `EEC_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
    end else begin
      if (aw_take) begin
        aw_have_q <= 1'b1;
        awaddr_q <= AWADDR;
      end
      if (w_take) begin
        w_have_q <= 1'b1;
        wdata_q <= WDATA;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `EEC_RESP_OKAY : `EEC_RESP_SLVERR;
      end else if (bvalid_q & BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // configuration registers; all full-word, strobes ignored
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      imask_q <= `EEC_RST_MASK;
      emask_q <= `EEC_RST_MASK;
      trig_q <= '0;
    end else begin
      if (wr_imask) imask_q <= wdata_q[`EEC_LINES-1:0]; // [R3]
      if (wr_emask) emask_q <= wdata_q[`EEC_LINES-1:0]; // [R3]
      if (wr_rise) trig_q.rise <= wdata_q[`EEC_LINES-1:0]; // [R2]
      if (wr_fall) trig_q.fall <= wdata_q[`EEC_LINES-1:0]; // [R2]
    end
  end

  generate
    for (g = 0; g < `EEC_EXT_LINES; g++) begin : g_sel
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) sel_q[g] <= `EEC_RST_SEL;
        else if (wr_mux & (mux_word == 2'(g / 4))) sel_q[g] <= wdata_q[(g % 4) * 8 +: `EEC_SEL_W]; // [R6]
      end
    end
  endgenerate

  // pending: a new edge wins over a same-cycle clear
  assign clr_vec = wr_pend ? wdata_q[`EEC_LINES-1:0] : '0; // [R7]
  assign pend_d = (pend_q & ~clr_vec) | set_vec; // [R4]

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pend_q <= '0;
      evt_q <= '0;
    end else begin
      pend_q <= pend_d;
      evt_q <= set_vec & emask_q; // [R1]
    end
  end

  assign IRQ = |(pend_q & imask_q); // [R3]
  assign EVT = evt_q;
  assign WAKEUP = IRQ | (|evt_q); // [R1]

  // axi read path
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  wire ar_take = ARVALID & ARREADY;
  wire [1:0] rd_word = ARADDR[3:2];
  wire rd_is_mux = (ARADDR >= `EEC_OFF_MUX0) & (ARADDR <= `EEC_OFF_MUX3) & (ARADDR[1:0] == 2'h0);
  wire rd_hit = rd_is_mux | (ARADDR == `EEC_OFF_IMASK) | (ARADDR == `EEC_OFF_EMASK) |
                (ARADDR == `EEC_OFF_RISE) | (ARADDR == `EEC_OFF_FALL) | (ARADDR == `EEC_OFF_PEND);
  wire [31:0] rd_val =
    (ARADDR == `EEC_OFF_IMASK) ? {3'h0, imask_q} :
    (ARADDR == `EEC_OFF_EMASK) ? {3'h0, emask_q} :
    (ARADDR == `EEC_OFF_RISE) ? {3'h0, trig_q.rise} :
    (ARADDR == `EEC_OFF_FALL) ? {3'h0, trig_q.fall} :
    (ARADDR == `EEC_OFF_PEND) ? {3'h0, pend_q} :
    rd_is_mux ? rd_mux : 32'h00000000;

  generate
    for (g = 0; g < 4; g++) begin : g_rdmux
      assign rd_mux[g * 8 +: 8] = {1'b0, sel_q[rd_word * 4 + g]};
    end
  endgenerate

  assign ARREADY = ~rvalid_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= `EEC_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_hit ? `EEC_RESP_OKAY : `EEC_RESP_SLVERR;
    end else if (rvalid_q & RREADY) begin
      rvalid_q <= 1'b0;
    end
  end

  // checks
  pend_set_a: assert property (@(posedge CLK) disable iff (RST) // [R4]
    (|set_vec) |=> ((pend_q & $past(set_vec)) == $past(set_vec)))
    else $error("selected edge did not set pending");

  trig_only_a: assert property (@(posedge CLK) disable iff (RST) // [R2]
    ((pend_q & ~$past(pend_q) &
      ~$past((rise_pulse & trig_q.rise) | (fall_pulse & trig_q.fall))) == '0))
    else $error("pending set without a selected edge");

  mask_block_a: assert property (@(posedge CLK) disable iff (RST) // [R3]
    (imask_q == '0) [*2] |-> !IRQ)
    else $error("interrupt raised with all lines masked");

  evt_pulse_a: assert property (@(posedge CLK) disable iff (RST) // [R1]
    (|(set_vec & emask_q)) |=> (EVT != '0) && WAKEUP)
    else $error("unmasked edge gave no event and wake-up");

  evt_once_a: assert property (@(posedge CLK) disable iff (RST) // [R1]
    (EVT != '0) |=> ((EVT & $past(EVT) & ~$past(set_vec & emask_q)) == '0))
    else $error("event pulse held longer than one cycle");

  mux_route_a: assert property (@(posedge CLK) disable iff (RST) // [R6]
    (sel_q[0] < 7'(`EEC_GPIOS)) |-> (line_in[0] == GPIO[sel_q[0]]))
    else $error("external line zero not routed to its pin");

  pend_clear_a: assert property (@(posedge CLK) disable iff (RST) // [R7]
    wr_pend |=> ((pend_q & $past(wdata_q[`EEC_LINES-1:0]) & ~$past(set_vec)) == '0) &&
                ((pend_q & $past(pend_q & ~wdata_q[`EEC_LINES-1:0])) == $past(pend_q & ~wdata_q[`EEC_LINES-1:0])))
    else $error("pending write-one-to-clear misbehaved");
endmodule

// file: dv/edge_source_model.sv
/*
  Model of the pins and internal sources that feed the edge event controller.
  Assumes the bench calls its tasks; edges land at any phase of CLK.
*/
`timescale 1ns/1ps

module edge_source_model (
  // pin and internal source levels
  output logic [83:0] GPIO,
  output logic [12:0] INT_SRC
);
  logic [96:0] lvl_q = '0;

  assign GPIO = lvl_q[83:0];
  assign INT_SRC = lvl_q[96:84];

  // level change on one source, index 84 and up are internal
  // changes land 7 ns after the call, away from the sampling edge
  task automatic set_pin(input int i, input logic v);
    #7;
    lvl_q[i] = v;
  endtask

  // pulse narrower than a clock period
  task automatic pulse(input int i, input int w);
    #7;
    lvl_q[i] = ~lvl_q[i];
    #w;
    lvl_q[i] = ~lvl_q[i];
  endtask
endmodule

// file: dv/edge_event_line_controller_test.sv
/*
  Self-checking bench for the edge event controller, register bus and edge scenarios.
  Assumes edge_source_model drives the line sources asynchronously.
*/
`timescale 1ns/1ps
`include "edge_event_defs.svh"

module edge_event_line_controller_test;
  localparam logic [1:0] ok = `EEC_RESP_OKAY;
  localparam logic [1:0] err = `EEC_RESP_SLVERR;
  localparam logic [6:0] pend = `EEC_OFF_PEND;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [6:0] AWADDR = 7'h00;
  logic [6:0] ARADDR = 7'h00;
  logic AWVALID = 1'b0;
  logic WVALID = 1'b0;
  logic BREADY = 1'b0;
  logic ARVALID = 1'b0;
  logic RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'hF;
  logic [31:0] RDATA;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ, WAKEUP;
  logic [1:0] BRESP, RRESP;
  logic [83:0] GPIO;
  logic [12:0] INT_SRC;
  edge_event_pkg::line_vec_t EVT;
  int n_errors = 0;
  int checks = 0;

  initial forever #20 CLK = ~CLK;

  edge_event_ctrl edge_event_ctrl_inst (
    .CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .GPIO(GPIO), .INT_SRC(INT_SRC), .IRQ(IRQ), .EVT(EVT), .WAKEUP(WAKEUP)
  );
  edge_source_model src (.GPIO(GPIO), .INT_SRC(INT_SRC));

  task automatic tally_and_finish();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_limit(input int n);
    if (n >= 50) begin
      n_errors++;
      $display("ERROR %0t bus answer missing", $time);
      tally_and_finish();
    end
  endtask

  // write both channels together, release each once taken
  task automatic wr(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1 && n < 50);
    bus_limit(n);
    cmp({30'h0, BRESP}, {30'h0, r});
    BREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic rd(input logic [6:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1 && n < 50);
    bus_limit(n);
    cmp(RDATA, d);
    cmp({30'h0, RRESP}, {30'h0, r});
    RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  task automatic t_regs();
    rd(`EEC_OFF_IMASK, 32'h0, ok);
    rd(pend, 32'h0, ok);
    wr(`EEC_OFF_RISE, 32'hFFFFFFFF, ok);
    rd(`EEC_OFF_RISE, 32'h1FFFFFFF, ok);
    wr(7'h30, 32'h1, err);
    rd(7'h30, 32'h0, err);
    wr(`EEC_OFF_RISE, 32'h1, ok);
    $display("t_regs done");
  endtask

  // line 0 fed from pin 5, rising edge only
  task automatic t_rise();
    wr(`EEC_OFF_MUX0, 32'h05, ok);
    wr(`EEC_OFF_IMASK, 32'h1, ok);
    wr(pend, 32'h1FFFFFFF, ok);
    src.pulse(5, 8);
    repeat (4) @(posedge CLK);
    rd(pend, 32'h1, ok);
    cmp({31'h0, IRQ}, 32'h1);
    wr(pend, 32'h0, ok);
    rd(pend, 32'h1, ok);
    wr(pend, 32'h1, ok);
    rd(pend, 32'h0, ok);
    cmp({31'h0, IRQ}, 32'h0);
    wr(`EEC_OFF_IMASK, 32'h0, ok);
    src.pulse(5, 8);
    repeat (4) @(posedge CLK);
    rd(pend, 32'h1, ok);
    cmp({31'h0, IRQ}, 32'h0);
    wr(pend, 32'h1, ok);
    $display("t_rise done");
  endtask

  // internal line 16, falling edge only, event enabled, interrupt masked
  task automatic t_fall();
    int e;
    int w;
    e = 0;
    w = 0;
    wr(`EEC_OFF_FALL, 32'h10000, ok);
    wr(`EEC_OFF_EMASK, 32'h10000, ok);
    src.set_pin(84, 1'b1);
    repeat (4) @(posedge CLK);
    rd(pend, 32'h0, ok);
    src.set_pin(84, 1'b0);
    for (int i = 0; i < 8; i++) begin
      @(posedge CLK);
      e += (EVT[16] === 1'b1);
      w += (WAKEUP === 1'b1);
    end
    cmp(e, 32'h1);
    cmp(w, 32'h1);
    rd(pend, 32'h10000, ok);
    cmp({31'h0, IRQ}, 32'h0);
    $display("t_fall done");
  endtask

  // line 15 fed from the last pin, both edges
  task automatic t_both();
    wr(`EEC_OFF_MUX3, 32'h53000000, ok);
    rd(`EEC_OFF_MUX3, 32'h53000000, ok);
    wr(`EEC_OFF_RISE, 32'h8001, ok);
    wr(`EEC_OFF_FALL, 32'h18000, ok);
    wr(pend, 32'h1FFFFFFF, ok);
    src.set_pin(83, 1'b1);
    repeat (4) @(posedge CLK);
    rd(pend, 32'h8000, ok);
    wr(pend, 32'h8000, ok);
    src.set_pin(83, 1'b0);
    repeat (4) @(posedge CLK);
    rd(pend, 32'h8000, ok);
    $display("t_both done");
  endtask

  // reset held for two cycles
  initial begin
    repeat (2) @(posedge CLK);
    RST <= 1'b0;
    t_regs();
    t_rise();
    t_fall();
    t_both();
    tally_and_finish();
  end
endmodule
